// ==== include/countdown_sequencer_regs.vh ====
// register map, field positions and timing constants of the sequencer
`ifndef COUNTDOWN_SEQUENCER_REGS_VH
`define COUNTDOWN_SEQUENCER_REGS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADDR_CTRL       5'h00
`define ADDR_STATUS     5'h04
`define ADDR_CAUSE      5'h08
`define ADDR_INT_STAT   5'h0c
`define ADDR_INT_CLR    5'h10
`define ADDR_INT_EN     5'h14
`define ADDR_LSB        2
`define ADDR_MSB        5

// ****************************************************************
// fields
// ****************************************************************
`define CTRL_START      0
`define CTRL_ENABLE     1
`define CTRL_RESET_VAL  2'h0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define NUM_EVENTS      5
`define EV_STARTED      0
`define EV_IGNITION     1
`define EV_COMMIT       2
`define EV_CUTOFF       3
`define EV_SEPARATED    4

// ****************************************************************
// cutoff source bits and per-phase masks
// ****************************************************************
`define NUM_CUT         12
`define CUT_MASK_AUTO   12'h07f
`define CUT_MASK_IGN    12'hf13
`define CUT_MASK_COMMIT 12'h003
`define NUM_PREP        14
`define NUM_IGN         5
`define NUM_DET         9

// ****************************************************************
// cutoff cause codes
// ****************************************************************
`define CAUSE_NONE      3'h0
`define CAUSE_SIGNAL    3'h1
`define CAUSE_PREP_LOST 3'h2
`define CAUSE_IGN_READY 3'h3
`define CAUSE_ENGINES   3'h4
`define CAUSE_LAUNCH    3'h5

// ****************************************************************
// count points in seconds before zero, second length, clock period and launch failure window
// ****************************************************************
`define T_AUTO_START    8'hbb
`define T_IGNITION      8'h03
`define T_COMMIT        8'h00
`define SECOND_NS       1000000000
`define CLK_PERIOD_NS   4
`define LAUNCH_FAIL_SEC 8'h05

`endif

// ==== rtl/countdown_sequencer.v ====
// terminal countdown sequencer with AXI4-Lite registers
//
// Function
// - The automatic count is taken over at T-187 once firing preparation is complete.
// - A start is refused, or a count before ignition ended, when launch readiness drops.
// - A running count has no hold; only a cutoff stops it.
// - Starting needs every first-stage firing preparation condition true.
// - The second-stage ready summary, true only when all its conditions hold, feeds preparation.
// - The guidance ready summary, true only when all its conditions hold, feeds preparation.
// - Detection ready is true only when no detection fault condition is present.
// - Ignition needs all ready-for-ignition conditions plus the three summaries.
// - A missing ignition condition at time for ignition ends the count.
// - After such an end the count restarts only from the start of the sequence.
// - After ignition starts, ignition conditions no longer end the count.
// - From start to ignition the listed pre-ignition sources cause cutoff.
// - From ignition to commit the listed post-ignition sources cause cutoff.
// - Commit needs time for commit, all engines running and no cutoff.
// - From commit to separation only manual cutoffs or launch failure cut off.
// - Ignition is commanded at T-3 and launch commit is given at T-0.
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "countdown_sequencer_regs.vh"

module countdown_sequencer #(
    parameter [31:0] TICK_CYC = `SECOND_NS / `CLK_PERIOD_NS
) (
    input  wire                  CLK,
    input  wire                  RST_N,
    input  wire                  CE,
    input  wire [`ADDR_MSB-1:0]  S_AXI_AWADDR,
    input  wire                  S_AXI_AWVALID,
    output reg                   S_AXI_AWREADY,
    input  wire [31:0]           S_AXI_WDATA,
    input  wire [3:0]            S_AXI_WSTRB,
    input  wire                  S_AXI_WVALID,
    output reg                   S_AXI_WREADY,
    output reg  [1:0]            S_AXI_BRESP,
    output reg                   S_AXI_BVALID,
    input  wire                  S_AXI_BREADY,
    input  wire [`ADDR_MSB-1:0]  S_AXI_ARADDR,
    input  wire                  S_AXI_ARVALID,
    output reg                   S_AXI_ARREADY,
    output reg  [31:0]           S_AXI_RDATA,
    output reg  [1:0]            S_AXI_RRESP,
    output reg                   S_AXI_RVALID,
    input  wire                  S_AXI_RREADY,
    input  wire [`NUM_PREP-1:0]  FIRING_PREP_OK,
    input  wire                  STAGE2_READY,
    input  wire                  GUIDANCE_READY,
    input  wire [`NUM_DET-1:0]   DETECT_FAULT,
    input  wire [`NUM_IGN-1:0]   IGNITION_COND_OK,
    input  wire [`NUM_CUT-1:0]   CUTOFF_SRC,
    input  wire                  ALL_ENGINES_RUNNING,
    input  wire                  LIFTOFF,
    input  wire                  PLUG_SEPARATED,
    output reg                   SEQ_ACTIVE,
    output reg                   IGNITION_CMD,
    output reg                   COMMIT_CMD,
    output reg                   CUTOFF_CMD,
    output reg                   IRQ
);

// ****************************************************************
// states
// ****************************************************************
localparam [2:0] ST_IDLE   = 3'h0;
localparam [2:0] ST_AUTO   = 3'h1;
localparam [2:0] ST_IGN    = 3'h2;
localparam [2:0] ST_COMMIT = 3'h3;
localparam [2:0] ST_DONE   = 3'h4;
localparam [2:0] ST_CUTOFF = 3'h5;

// ****************************************************************
// address decode
// ****************************************************************
function is_reg;
    input [`ADDR_MSB-1:0] addr;
    input [`ADDR_MSB-1:0] byte_addr;
    begin
        is_reg = addr == byte_addr;
    end
endfunction

reg  [`ADDR_MSB-1:0]   awaddr_q;
reg  [31:0]            wdata_q;
reg  [3:0]             wstrb_q;
reg  [1:0]             ctrl_q;
reg                    start_q;
reg  [`NUM_EVENTS-1:0] int_stat_q;
reg  [`NUM_EVENTS-1:0] int_en_q;
reg  [`NUM_EVENTS-1:0] int_clr;
reg  [2:0]             state_q;
reg  [2:0]             state_d;
reg  [7:0]             sec_q;
reg  [7:0]             sec_d;
reg  [31:0]            tick_cnt_q;
reg                    tick_q;
reg                    liftoff_q;
reg  [2:0]             cause_q;
reg  [2:0]             cause_d;
reg  [`NUM_CUT-1:0]    cut_snap_q;
reg  [`NUM_EVENTS-1:0] ev;
reg  [31:0]            rd_val;
reg                    rd_ok;
wire                   wr_fire;
wire                   detect_ready;
wire                   prep_ok;
wire                   ign_ok;
wire [`NUM_CUT-1:0]    cut_auto;
wire [`NUM_CUT-1:0]    cut_ign;
wire [`NUM_CUT-1:0]    cut_commit;

// ****************************************************************
// interlock summing
// ****************************************************************
assign detect_ready = ~|DETECT_FAULT;
assign prep_ok      = &FIRING_PREP_OK && STAGE2_READY
                   && GUIDANCE_READY && detect_ready;
assign ign_ok       = prep_ok && &IGNITION_COND_OK;
assign cut_auto     = CUTOFF_SRC & `CUT_MASK_AUTO;
assign cut_ign      = CUTOFF_SRC & `CUT_MASK_IGN;
assign cut_commit   = CUTOFF_SRC & `CUT_MASK_COMMIT;
assign wr_fire      = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;

// ****************************************************************
// sequencer next state
// ****************************************************************
always @* begin
    state_d = state_q;
    sec_d   = sec_q;
    cause_d = cause_q;
    case (state_q)
    ST_IDLE, ST_CUTOFF: begin
        if (start_q && ctrl_q[`CTRL_ENABLE] && prep_ok) begin
            state_d = ST_AUTO;
            sec_d   = `T_AUTO_START;
            cause_d = `CAUSE_NONE;
        end
    end
    ST_AUTO: begin
        if (|cut_auto) begin
            state_d = ST_CUTOFF;
            cause_d = `CAUSE_SIGNAL;
        end else if (!prep_ok) begin
            state_d = ST_CUTOFF;
            cause_d = `CAUSE_PREP_LOST;
        end else if (sec_q == `T_IGNITION) begin
            if (ign_ok) begin
                state_d = ST_IGN;
            end else begin
                state_d = ST_CUTOFF;
                cause_d = `CAUSE_IGN_READY;
            end
        end else if (tick_q) begin
            sec_d = sec_q - 8'h01;
        end
    end
    ST_IGN: begin
        if (|cut_ign) begin
            state_d = ST_CUTOFF;
            cause_d = `CAUSE_SIGNAL;
        end else if (sec_q == `T_COMMIT) begin
            if (ALL_ENGINES_RUNNING) begin
                state_d = ST_COMMIT;
                sec_d   = `LAUNCH_FAIL_SEC;
            end else begin
                state_d = ST_CUTOFF;
                cause_d = `CAUSE_ENGINES;
            end
        end else if (tick_q) begin
            sec_d = sec_q - 8'h01;
        end
    end
    ST_COMMIT: begin
        if (|cut_commit) begin
            state_d = ST_CUTOFF;
            cause_d = `CAUSE_SIGNAL;
        end else if (PLUG_SEPARATED) begin
            state_d = ST_DONE;
        end else if (!liftoff_q && sec_q == 8'h00) begin
            state_d = ST_CUTOFF;
            cause_d = `CAUSE_LAUNCH;
        end else if (tick_q && sec_q != 8'h00) begin
            sec_d = sec_q - 8'h01;
        end
    end
    ST_DONE: begin
        state_d = ST_DONE;
    end
    default: begin
        state_d = ST_IDLE;
    end
    endcase
end

always @* begin
    ev = {`NUM_EVENTS{1'b0}};
    ev[`EV_STARTED]   = state_d == ST_AUTO   && state_q != ST_AUTO;
    ev[`EV_IGNITION]  = state_d == ST_IGN    && state_q != ST_IGN;
    ev[`EV_COMMIT]    = state_d == ST_COMMIT && state_q != ST_COMMIT;
    ev[`EV_CUTOFF]    = state_d == ST_CUTOFF && state_q != ST_CUTOFF;
    ev[`EV_SEPARATED] = state_d == ST_DONE   && state_q != ST_DONE;
end

// ****************************************************************
// sequencer registers
// ****************************************************************
always @(posedge CLK) begin
    if (!RST_N) begin
        state_q      <= ST_IDLE;
        sec_q        <= 8'h00;
        cause_q      <= `CAUSE_NONE;
        cut_snap_q   <= {`NUM_CUT{1'b0}};
        tick_cnt_q   <= 32'h0;
        tick_q       <= 1'b0;
        liftoff_q    <= 1'b0;
        SEQ_ACTIVE   <= 1'b0;
        IGNITION_CMD <= 1'b0;
        COMMIT_CMD   <= 1'b0;
        CUTOFF_CMD   <= 1'b0;
    end else if (CE) begin
        state_q <= state_d;
        sec_q   <= sec_d;
        cause_q <= cause_d;
        if (ev[`EV_CUTOFF]) begin
            cut_snap_q <= CUTOFF_SRC;
        end
        // second ticks restart with every new count
        if (ev[`EV_STARTED] || tick_cnt_q == TICK_CYC - 32'h1) begin
            tick_cnt_q <= 32'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
        tick_q <= !ev[`EV_STARTED] && tick_cnt_q == TICK_CYC - 32'h1;
        if (state_d != ST_COMMIT && state_d != ST_DONE) begin
            liftoff_q <= 1'b0;
        end else if (LIFTOFF) begin
            liftoff_q <= 1'b1;
        end
        SEQ_ACTIVE   <= state_d == ST_AUTO || state_d == ST_IGN
                     || state_d == ST_COMMIT;
        IGNITION_CMD <= state_d == ST_IGN || state_d == ST_COMMIT
                     || state_d == ST_DONE;
        COMMIT_CMD   <= state_d == ST_COMMIT || state_d == ST_DONE;
        CUTOFF_CMD   <= state_d == ST_CUTOFF;
    end
end

// ****************************************************************
// register write side
// ****************************************************************
always @* begin
    int_clr = {`NUM_EVENTS{1'b0}};
    if (wr_fire && is_reg(awaddr_q, `ADDR_INT_CLR) && wstrb_q[0]) begin
        int_clr = wdata_q[`NUM_EVENTS-1:0];
    end
end

always @(posedge CLK) begin
    if (!RST_N) begin
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
        S_AXI_BVALID  <= 1'b0;
        S_AXI_BRESP   <= `RESP_OKAY;
        awaddr_q      <= {`ADDR_MSB{1'b0}};
        wdata_q       <= 32'h0;
        wstrb_q       <= 4'h0;
        ctrl_q        <= `CTRL_RESET_VAL;
        start_q       <= 1'b0;
        int_en_q      <= {`NUM_EVENTS{1'b0}};
        int_stat_q    <= {`NUM_EVENTS{1'b0}};
        IRQ           <= 1'b0;
    end else if (CE) begin
        start_q <= 1'b0;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            awaddr_q      <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            wdata_q      <= S_AXI_WDATA;
            wstrb_q      <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
        end
        if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= `RESP_OKAY;
            if (is_reg(awaddr_q, `ADDR_CTRL) && wstrb_q[0]) begin
                ctrl_q  <= wdata_q[1:0] & 2'h2;
                start_q <= wdata_q[`CTRL_START];
            end else if (is_reg(awaddr_q, `ADDR_INT_EN) && wstrb_q[0]) begin
                int_en_q <= wdata_q[`NUM_EVENTS-1:0];
            end else if (awaddr_q > `ADDR_INT_EN
                      || awaddr_q[`ADDR_LSB-1:0] != 2'h0) begin
                S_AXI_BRESP <= `RESP_SLVERR;
            end
        end
        if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID  <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
        end
        // a new event beats a clear in the same cycle
        int_stat_q <= (int_stat_q & ~int_clr) | ev;
        IRQ        <= |(((int_stat_q & ~int_clr) | ev) & int_en_q);
    end
end

// ****************************************************************
// register read side
// ****************************************************************
always @* begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    if (is_reg(S_AXI_ARADDR, `ADDR_CTRL)) begin
        rd_val = {30'h0, ctrl_q};
    end else if (is_reg(S_AXI_ARADDR, `ADDR_STATUS)) begin
        rd_val = {15'h0, liftoff_q, sec_q, 1'b0, cause_q, 1'b0, state_q};
    end else if (is_reg(S_AXI_ARADDR, `ADDR_CAUSE)) begin
        rd_val = {20'h0, cut_snap_q};
    end else if (is_reg(S_AXI_ARADDR, `ADDR_INT_STAT)) begin
        rd_val = {27'h0, int_stat_q};
    end else if (is_reg(S_AXI_ARADDR, `ADDR_INT_CLR)) begin
        rd_val = 32'h0;
    end else if (is_reg(S_AXI_ARADDR, `ADDR_INT_EN)) begin
        rd_val = {27'h0, int_en_q};
    end else begin
        rd_ok = 1'b0;
    end
end

always @(posedge CLK) begin
    if (!RST_N) begin
        S_AXI_ARREADY <= 1'b1;
        S_AXI_RVALID  <= 1'b0;
        S_AXI_RDATA   <= 32'h0;
        S_AXI_RRESP   <= `RESP_OKAY;
    end else if (CE) begin
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_val;
            S_AXI_RRESP   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end
end

endmodule // countdown_sequencer

// ==== verif/sequencer_monitor.sv ====
// port assertions for the countdown sequencer
`timescale 1ns/1ps
`include "countdown_sequencer_regs.vh"
module sequencer_monitor (
    input wire                 CLK,
    input wire                 RST_N,
    input wire [`NUM_PREP-1:0] FIRING_PREP_OK,
    input wire                 STAGE2_READY,
    input wire                 GUIDANCE_READY,
    input wire [`NUM_DET-1:0]  DETECT_FAULT,
    input wire [`NUM_IGN-1:0]  IGNITION_COND_OK,
    input wire [`NUM_CUT-1:0]  CUTOFF_SRC,
    input wire                 ALL_ENGINES_RUNNING,
    input wire                 SEQ_ACTIVE,
    input wire                 IGNITION_CMD,
    input wire                 COMMIT_CMD,
    input wire                 CUTOFF_CMD
);
    // ********************
    // phases
    // ********************
    wire auto_ph = SEQ_ACTIVE && !IGNITION_CMD;
    wire ign_ph  = SEQ_ACTIVE && IGNITION_CMD && !COMMIT_CMD;
    wire ign_cut = (CUTOFF_SRC & `CUT_MASK_IGN) != 0;
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // ********************
    // properties
    // ********************
    property p_cut_alone;
        CUTOFF_CMD |-> !SEQ_ACTIVE && !IGNITION_CMD && !COMMIT_CMD;
    endproperty
    a_cut_alone: assert property (p_cut_alone) else $error("cutoff mix");
    property p_start;
        $rose(SEQ_ACTIVE) |-> $past(&FIRING_PREP_OK && STAGE2_READY
            && GUIDANCE_READY && DETECT_FAULT == 0);
    endproperty
    a_start: assert property (p_start) else $error("start unready");
    property p_prep_lost;
        auto_ph && !(&FIRING_PREP_OK) |=> CUTOFF_CMD;
    endproperty
    a_prep_lost: assert property (p_prep_lost) else $error("prep lost");
    property p_auto_cut;
        auto_ph && (CUTOFF_SRC & `CUT_MASK_AUTO) != 0 |=> CUTOFF_CMD;
    endproperty
    a_auto_cut: assert property (p_auto_cut) else $error("auto cut");
    property p_ign_go;
        $rose(IGNITION_CMD) |-> $past(&IGNITION_COND_OK && SEQ_ACTIVE);
    endproperty
    a_ign_go: assert property (p_ign_go) else $error("ign unready");
    property p_ign_cut;
        ign_ph && ign_cut |=> CUTOFF_CMD;
    endproperty
    a_ign_cut: assert property (p_ign_cut) else $error("ign cut");
    property p_ign_hold;
        ign_ph && !ign_cut && ALL_ENGINES_RUNNING |=> !CUTOFF_CMD;
    endproperty
    a_ign_hold: assert property (p_ign_hold) else $error("ign held");
    property p_commit;
        $rose(COMMIT_CMD) |-> $past(ALL_ENGINES_RUNNING && !ign_cut);
    endproperty
    a_commit: assert property (p_commit) else $error("bad commit");
endmodule // sequencer_monitor

bind countdown_sequencer sequencer_monitor u_mon (
    .CLK(CLK), .RST_N(RST_N), .FIRING_PREP_OK(FIRING_PREP_OK),
    .STAGE2_READY(STAGE2_READY), .GUIDANCE_READY(GUIDANCE_READY),
    .DETECT_FAULT(DETECT_FAULT), .IGNITION_COND_OK(IGNITION_COND_OK),
    .CUTOFF_SRC(CUTOFF_SRC), .ALL_ENGINES_RUNNING(ALL_ENGINES_RUNNING),
    .SEQ_ACTIVE(SEQ_ACTIVE), .IGNITION_CMD(IGNITION_CMD),
    .COMMIT_CMD(COMMIT_CMD), .CUTOFF_CMD(CUTOFF_CMD));

// ==== verif/ground_equipment.sv ====
// model of the stage and ground equipment readiness summaries
`timescale 1ns/1ps
`include "countdown_sequencer_regs.vh"
module ground_equipment (
    input  wire [13:0]          s1_ok,
    input  wire [14:0]          s2_cond,
    input  wire [13:0]          gu_cond,
    input  wire [8:0]           det_fault,
    output wire [`NUM_PREP-1:0] prep_ok,
    output wire                 stage2_ready,
    output wire                 guidance_ready,
    output wire [`NUM_DET-1:0]  detect_fault
);
    assign prep_ok        = s1_ok;
    assign stage2_ready   = &s2_cond;
    assign guidance_ready = &gu_cond;
    assign detect_fault   = det_fault;
endmodule // ground_equipment

// ==== verif/countdown_sequencer_tb.sv ====
// self-checking bench for the countdown sequencer
`timescale 1ns/1ps
`include "countdown_sequencer_regs.vh"
module countdown_sequencer_tb;
    // ********************
    // signals
    // ********************
    logic                 CLK, RST_N, CE, IRQ, LIFTOFF, PLUG_SEPARATED;
    logic [`ADDR_MSB-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [3:0]           S_AXI_WSTRB;
    logic                 S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
    logic                 S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
    logic                 S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic                 S_AXI_RREADY, STAGE2_READY, GUIDANCE_READY;
    logic [31:0]          S_AXI_WDATA, S_AXI_RDATA, m;
    logic [1:0]           S_AXI_BRESP, S_AXI_RRESP;
    logic [`NUM_PREP-1:0] FIRING_PREP_OK;
    logic [`NUM_DET-1:0]  DETECT_FAULT;
    logic [`NUM_IGN-1:0]  IGNITION_COND_OK;
    logic [`NUM_CUT-1:0]  CUTOFF_SRC, cut;
    logic                 ALL_ENGINES_RUNNING, SEQ_ACTIVE, IGNITION_CMD;
    logic                 COMMIT_CMD, CUTOFF_CMD;
    logic [13:0]          s1_ok, gu_cond;
    logic [14:0]          s2_cond;
    logic [8:0]           det_fault;
    logic [33:0]          exp_q[$], e;
    logic [31:0]          msk_q[$];
    int                   n_errors, comparisons;
    wire  [3:0]           cmds = {SEQ_ACTIVE, IGNITION_CMD, COMMIT_CMD,
                                  CUTOFF_CMD};

    countdown_sequencer #(.TICK_CYC(32'd20)) u_dut (.*);
    ground_equipment u_gse (.s1_ok(s1_ok), .s2_cond(s2_cond),
        .gu_cond(gu_cond), .det_fault(det_fault), .prep_ok(FIRING_PREP_OK),
        .stage2_ready(STAGE2_READY), .guidance_ready(GUIDANCE_READY),
        .detect_fault(DETECT_FAULT));

    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    // ********************
    // checking and bus tasks
    // ********************
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic tmo;
        chk(1'b0, "wait limit reached");
        wrap_up();
    endtask
    always @(posedge CLK) begin
        if (S_AXI_RVALID === 1'b1 && S_AXI_RREADY) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk((S_AXI_RDATA & m) === (e[31:0] & m)
                && S_AXI_RRESP === e[33:32], "read data");
        end
    end
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        @(posedge CLK);
        S_AXI_AWADDR  <= a;
        S_AXI_WDATA   <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID  <= 1'b1;
        S_AXI_BREADY  <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1 && n < 100);
        S_AXI_BREADY <= 1'b0;
        if (S_AXI_BVALID !== 1'b1) tmo();
        chk(S_AXI_BRESP === r, "write response");
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] x, k,
                      input logic [1:0] r);
        int n;
        exp_q.push_back({r, x});
        msk_q.push_back(k);
        @(posedge CLK);
        S_AXI_ARADDR  <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY  <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1 && n < 100);
        S_AXI_RREADY <= 1'b0;
        if (S_AXI_RVALID !== 1'b1) tmo();
    endtask
    task automatic stat(input logic [31:0] x, k);
        rd(`ADDR_STATUS, x, k, `RESP_OKAY);
    endtask
    task automatic wait_out(input logic [3:0] x, input int lim);
        int n;
        n = 0;
        while (cmds !== x && n < lim) begin
            @(posedge CLK);
            n++;
        end
        chk(cmds === x, "command outputs");
        if (cmds !== x) wrap_up();
    endtask
    task automatic good;
        {s1_ok, s2_cond, gu_cond, IGNITION_COND_OK} <= '1;
        det_fault <= '0;
        CUTOFF_SRC <= '0;
        @(posedge CLK);
    endtask
    task automatic go;
        wr(`ADDR_CTRL, 32'h3, `RESP_OKAY);
        wait_out(4'b1000, 4);
    endtask
    // ********************
    // scenarios
    // ********************
    initial begin
        void'($urandom(32'h5d1d));
        {CE, S_AXI_WSTRB, s1_ok, s2_cond, gu_cond, IGNITION_COND_OK} = '1;
        {RST_N, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_AWVALID, S_AXI_WVALID,
         S_AXI_WDATA, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, CUTOFF_SRC,
         ALL_ENGINES_RUNNING, LIFTOFF, PLUG_SEPARATED, det_fault} = '0;
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        wait_out(4'b0000, 1);
        stat(32'h0, 32'hffff);
        rd(5'h1f, 32'h0, 32'h0, `RESP_SLVERR);
        wr(`ADDR_INT_EN, 32'h1f, `RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            case (k)
                0: s1_ok[$urandom_range(13, 0)] <= 1'b0;
                1: s2_cond[$urandom_range(14, 0)] <= 1'b0;
                2: gu_cond[$urandom_range(13, 0)] <= 1'b0;
                default: det_fault[$urandom_range(8, 0)] <= 1'b1;
            endcase
            wr(`ADDR_CTRL, 32'h3, `RESP_OKAY);
            stat(32'h0, 32'h7);
            good();
        end
        go();
        stat({`T_AUTO_START, 8'h01}, 32'hff07);
        chk(IRQ === 1'b1, "interrupt raised");
        wr(`ADDR_INT_CLR, 32'h1f, `RESP_OKAY);
        rd(`ADDR_INT_STAT, 32'h0, 32'h1f, `RESP_OKAY);
        chk(IRQ === 1'b0, "interrupt cleared");
        s1_ok[$urandom_range(13, 0)] <= 1'b0;
        wait_out(4'b0001, 4);
        stat(32'h25, 32'h77);
        good();
        go();
        stat({`T_AUTO_START, 8'h01}, 32'hff07);
        CUTOFF_SRC <= 12'hf80;
        repeat (8) @(posedge CLK);
        wait_out(4'b1000, 0);
        cut = 12'h1 << $urandom_range(6, 0);
        CUTOFF_SRC <= cut;
        wait_out(4'b0001, 4);
        rd(`ADDR_CAUSE, {20'h0, cut}, 32'hfff, `RESP_OKAY);
        good();
        go();
        IGNITION_COND_OK[$urandom_range(4, 0)] <= 1'b0;
        wait_out(4'b0001, 4000);
        stat(32'h35, 32'h77);
        good();
        wr(`ADDR_INT_EN, 32'h0, `RESP_OKAY);
        wr(`ADDR_INT_CLR, 32'h1f, `RESP_OKAY);
        go();
        wait_out(4'b1100, 4000);
        stat({`T_IGNITION, 8'h02}, 32'hff07);
        IGNITION_COND_OK <= '0;
        CUTOFF_SRC <= 12'h0e0;
        ALL_ENGINES_RUNNING <= 1'b1;
        wait_out(4'b1110, 100);
        stat({`LAUNCH_FAIL_SEC, 8'h03}, 32'hff07);
        CUTOFF_SRC <= 12'hffc;
        LIFTOFF <= 1'b1;
        repeat (8) @(posedge CLK);
        wait_out(4'b1110, 0);
        PLUG_SEPARATED <= 1'b1;
        wait_out(4'b0110, 8);
        rd(`ADDR_INT_STAT, 32'h17, 32'h1f, `RESP_OKAY);
        chk(IRQ === 1'b0, "interrupt masked");
        RST_N <= 1'b0;
        {LIFTOFF, PLUG_SEPARATED} <= 2'b00;
        good();
        RST_N <= 1'b1;
        wait_out(4'b0000, 2);
        go();
        wait_out(4'b1100, 4000);
        CUTOFF_SRC <= 12'h100 << $urandom_range(3, 0);
        wait_out(4'b0001, 4);
        stat(32'h15, 32'h77);
        good();
        go();
        wait_out(4'b1110, 4000);
        CE <= 1'b0;
        repeat (150) @(posedge CLK);
        wait_out(4'b1110, 0);
        CE <= 1'b1;
        wait_out(4'b0001, 120);
        stat(32'h55, 32'h77);
        wrap_up();
    end
endmodule // countdown_sequencer_tb
